// *** common/isoe_defines.svh ***
`ifndef ISOE_DEFINES_SVH
`define ISOE_DEFINES_SVH

// Register regions, selected by address bits 7:6
`define ISOE_RGN_MISC 2'h0
`define ISOE_RGN_START 2'h1
`define ISOE_RGN_CNT 2'h2
`define ISOE_RGN_DATA 2'h3

// Word index inside the misc region
`define ISOE_IDX_CTRL 4'h0
`define ISOE_IDX_STAT 4'h1
`define ISOE_IDX_FRAME 4'h2
`define ISOE_IDX_VALID 4'h3
`define ISOE_IDX_CRCERR 4'h4

// Field positions
`define ISOE_CTRL_ZLR_BIT 0
`define ISOE_CTRL_IRQEN_BIT 1
`define ISOE_STAT_FLAG_BIT 0
`define ISOE_STAT_BANK_BIT 1

// Reset values
`define ISOE_CTRL_RST 2'h0
`define ISOE_VALID_RST 16'h0000
`define ISOE_START_RST 6'h00

// AXI responses
`define ISOE_RESP_OKAY 2'h0
`define ISOE_RESP_SLVERR 2'h2

// FIFO geometry
`define ISOE_NUM_EP 16
`define ISOE_FIFO_BYTES 11'h400
`define ISOE_START_PAD 4'h0

// Timing
`define ISOE_CLK_NS 40
`define ISOE_FRAME_NS 1000000
`define ISOE_GRACE_NS 20000

`endif

// *** common/isoe_pkg.sv ***
package isoe_pkg;

  typedef enum logic {
    ISOE_TX_IDLE,
    ISOE_TX_SEND
  } isoe_tx_state_t;

endpackage : isoe_pkg

// *** rtl/isoe_ep_ctr.sv ***
`timescale 1ns/1ns
module isoe_ep_ctr #(
  parameter int CNT_W = 10,
  parameter bit IS_IN = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic swap_i,
  input wire logic cpu_step_i,
  input wire logic usb_step_i,
  output logic [CNT_W-1:0] cpu_cnt_o,
  output logic [CNT_W-1:0] usb_cnt_o,
  output logic [CNT_W-1:0] frm_cnt_o
);

  logic [CNT_W-1:0] cpu_cnt_ff;
  logic [CNT_W-1:0] usb_cnt_ff;
  logic [CNT_W-1:0] frm_cnt_ff;
  wire [CNT_W-1:0] nxt_cpu_cnt = CNT_W'(cpu_cnt_ff + cpu_step_i);
  wire [CNT_W-1:0] nxt_usb_cnt = CNT_W'(usb_cnt_ff + usb_step_i);

  // Latch the frame's count and restart both pointers at the swap
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cpu_cnt_ff <= '0;
      usb_cnt_ff <= '0;
      frm_cnt_ff <= '0;
    end else if (swap_i) begin
      frm_cnt_ff <= IS_IN ? nxt_cpu_cnt : nxt_usb_cnt;
      cpu_cnt_ff <= '0;
      usb_cnt_ff <= '0;
    end else begin
      cpu_cnt_ff <= nxt_cpu_cnt;
      usb_cnt_ff <= nxt_usb_cnt;
    end
  end

  assign cpu_cnt_o = cpu_cnt_ff;
  assign usb_cnt_o = usb_cnt_ff;
  assign frm_cnt_o = frm_cnt_ff;

  ptr_restart_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    swap_i |=> (cpu_cnt_ff == '0) && (usb_cnt_ff == '0))
    else $error("pointers not restarted at frame start");
  count_latch_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    swap_i |=> frm_cnt_ff == (IS_IN ? $past(nxt_cpu_cnt) : $past(nxt_usb_cnt)))
    else $error("frame count not latched");

endmodule : isoe_ep_ctr

// *** rtl/isoe_engine.sv ***
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "isoe_defines.svh"
module isoe_engine #(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 10,
  parameter int MISS_CYC = (`ISOE_FRAME_NS + `ISOE_GRACE_NS) / `ISOE_CLK_NS
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic usb_sof_i,
  input wire logic [10:0] usb_frame_num_i,
  input wire logic usb_in_tok_i,
  input wire logic [2:0] usb_tok_ep_i,
  input wire logic usb_rx_valid_i,
  input wire logic [7:0] usb_rx_data_i,
  input wire logic [2:0] usb_rx_ep_i,
  input wire logic usb_rx_end_i,
  input wire logic usb_rx_crc_bad_i,
  output logic usb_tx_valid_o,
  output logic [7:0] usb_tx_data_o,
  output logic usb_tx_last_o,
  input wire logic usb_tx_ready_i,
  output logic usb_tx_zlp_o,
  output logic cpu_usb_irq_line_o
);

  localparam int NEP = `ISOE_NUM_EP;
  localparam int MISS_W = $clog2(MISS_CYC + 1);

  // Register state
  logic [1:0] ctrl_ff;
  logic [15:0] valid_ff;
  logic [5:0] start_ff [NEP];
  logic frame_start_irq_flag_ff;
  logic bank_ff;
  logic [10:0] frame_ff;
  logic [7:0] err_live_ff;
  logic [7:0] iso_crc_error_flags_ff;
  logic sof_seen_ff;
  logic [MISS_W-1:0] miss_cnt_ff;
  logic irq_ff;

  // Bus handshake state
  logic aw_rdy_ff;
  logic ar_rdy_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;

  // Transmit state
  isoe_pkg::isoe_tx_state_t state_ff;
  logic [2:0] tx_ep_ff;
  logic tx_valid_ff;
  logic [7:0] tx_data_ff;
  logic tx_last_ff;
  logic zlp_ff;

  // Two 1,024-byte banks, separate from the processor's memory
  logic [7:0] mem_ff [2 * `ISOE_FIFO_BYTES];

  // Per-endpoint geometry and pointers; 0-7 are OUT8-15, 8-15 are IN8-15
  logic [9:0] sa_arr [NEP];
  logic [10:0] sz_arr [NEP];
  logic [CNT_W-1:0] cpu_cnt [NEP];
  logic [CNT_W-1:0] usb_cnt [NEP];
  logic [CNT_W-1:0] frm_cnt [NEP];
  logic [NEP-1:0] cpu_step;
  logic [NEP-1:0] usb_step;

  // Frame start: real packet, or the interval counter after a miss
  wire zlr_en = ctrl_ff[`ISOE_CTRL_ZLR_BIT];
  wire irq_en = ctrl_ff[`ISOE_CTRL_IRQEN_BIT];
  wire miss_hit = sof_seen_ff & (miss_cnt_ff == MISS_W'(MISS_CYC - 1));
  wire fs = usb_sof_i | miss_hit;

  // Bus decode
  wire wr_en = aw_rdy_ff & s_axi_awvalid_i & s_axi_wvalid_i;
  wire rd_en = ar_rdy_ff & s_axi_arvalid_i;
  wire [1:0] wr_rgn = s_axi_awaddr_i[7:6];
  wire [3:0] wr_idx = s_axi_awaddr_i[5:2];
  wire [1:0] rd_rgn = s_axi_araddr_i[7:6];
  wire [3:0] rd_idx = s_axi_araddr_i[5:2];
  wire wr_misc = wr_en & (wr_rgn == `ISOE_RGN_MISC);
  wire wr_start = wr_en & (wr_rgn == `ISOE_RGN_START) & s_axi_wstrb_i[0];
  wire wr_ok = ((wr_rgn == `ISOE_RGN_MISC) & (wr_idx <= `ISOE_IDX_CRCERR)) |
               (wr_rgn == `ISOE_RGN_START) | ((wr_rgn == `ISOE_RGN_DATA) & wr_idx[3]);
  wire rd_ok = ((rd_rgn == `ISOE_RGN_MISC) & (rd_idx <= `ISOE_IDX_CRCERR)) |
               (rd_rgn == `ISOE_RGN_START) | (rd_rgn == `ISOE_RGN_CNT) |
               ((rd_rgn == `ISOE_RGN_DATA) & ~rd_idx[3]);
  wire push = wr_en & (wr_rgn == `ISOE_RGN_DATA) & wr_idx[3] & s_axi_wstrb_i[0];
  wire pop = rd_en & (rd_rgn == `ISOE_RGN_DATA) & ~rd_idx[3];
  wire flag_clr = wr_misc & (wr_idx == `ISOE_IDX_STAT) & s_axi_wstrb_i[0] &
                  s_axi_wdata_i[`ISOE_STAT_FLAG_BIT];

  // Hardware set wins over a software clear in the same cycle
  wire nxt_flag = fs | (frame_start_irq_flag_ff & ~flag_clr);

  // Memory addresses: processor uses the idle bank, USB the active one
  wire [9:0] push_addr = 10'(sa_arr[wr_idx] + cpu_cnt[wr_idx]);
  wire [9:0] pop_addr = 10'(sa_arr[rd_idx] + cpu_cnt[rd_idx]);
  wire [3:0] rx_slot = {1'b0, usb_rx_ep_i};
  wire [9:0] rx_addr = 10'(sa_arr[rx_slot] + usb_cnt[rx_slot]);
  wire [3:0] tx_slot = {1'b1, tx_ep_ff};
  wire [9:0] tx_addr = 10'(sa_arr[tx_slot] + usb_cnt[tx_slot]);
  wire [7:0] pop_byte = mem_ff[{~bank_ff, pop_addr}];
  wire [7:0] tx_byte = mem_ff[{bank_ff, tx_addr}];

  // IN token handling
  wire [3:0] tok_slot = {1'b1, usb_tok_ep_i};
  wire in_hit = (state_ff == isoe_pkg::ISOE_TX_IDLE) & usb_in_tok_i &
                valid_ff[tok_slot] & (usb_cnt[tok_slot] == '0);
  wire in_has = frm_cnt[tok_slot] != '0;
  wire tx_adv = (state_ff == isoe_pkg::ISOE_TX_SEND) & (~tx_valid_ff | usb_tx_ready_i);
  wire tx_more = usb_cnt[tx_slot] < frm_cnt[tx_slot];
  wire tx_take = tx_adv & tx_more;
  wire tx_is_last = CNT_W'(usb_cnt[tx_slot] + 1'b1) == frm_cnt[tx_slot];

  // CRC errors reported per OUT endpoint
  wire [7:0] err_set = (usb_rx_end_i & usb_rx_crc_bad_i & valid_ff[rx_slot]) ?
                       (8'h01 << usb_rx_ep_i) : 8'h00;

  // Geometry, room checks and one pointer block per endpoint
  genvar i;
  generate
    for (i = 0; i < NEP; i++) begin : g_ep
      wire [10:0] nxt_start;
      wire [10:0] room_cpu;
      wire [10:0] room_usb;
      if (i == NEP - 1) begin : g_last
        assign nxt_start = `ISOE_FIFO_BYTES;
      end else begin : g_mid
        assign nxt_start = {1'b0, start_ff[i+1], `ISOE_START_PAD};
      end
      assign sa_arr[i] = {start_ff[i], `ISOE_START_PAD};
      assign sz_arr[i] = (nxt_start > {1'b0, sa_arr[i]}) ?
                         11'(nxt_start - {1'b0, sa_arr[i]}) : 11'h000;
      assign room_cpu = {1'b0, cpu_cnt[i]};
      assign room_usb = {1'b0, usb_cnt[i]};
      if (i < NEP / 2) begin : g_out
        assign usb_step[i] = usb_rx_valid_i & (usb_rx_ep_i == 3'(i)) & valid_ff[i] &
                             (room_usb < sz_arr[i]) & ~&usb_cnt[i];
        assign cpu_step[i] = pop & (rd_idx == 4'(i)) & (cpu_cnt[i] < frm_cnt[i]);
      end else begin : g_in
        assign cpu_step[i] = push & (wr_idx == 4'(i)) &
                             (room_cpu < sz_arr[i]) & ~&cpu_cnt[i];
        assign usb_step[i] = tx_take & (tx_ep_ff == 3'(i - NEP / 2));
      end
      isoe_ep_ctr #(
        .CNT_W(CNT_W),
        .IS_IN(i >= NEP / 2)
      ) u_ctr (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .swap_i(fs),
        .cpu_step_i(cpu_step[i]),
        .usb_step_i(usb_step[i]),
        .cpu_cnt_o(cpu_cnt[i]),
        .usb_cnt_o(usb_cnt[i]),
        .frm_cnt_o(frm_cnt[i])
      );
    end
  endgenerate

  // Read data selection
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (rd_rgn)
      `ISOE_RGN_MISC: begin
        case (rd_idx)
          `ISOE_IDX_CTRL: nxt_rdata = {30'h0, ctrl_ff};
          `ISOE_IDX_STAT: nxt_rdata = {30'h0, bank_ff, frame_start_irq_flag_ff};
          `ISOE_IDX_FRAME: nxt_rdata = {21'h0, frame_ff};
          `ISOE_IDX_VALID: nxt_rdata = {16'h0, valid_ff};
          `ISOE_IDX_CRCERR: nxt_rdata = {24'h0, iso_crc_error_flags_ff};
          default: nxt_rdata = 32'h0000_0000;
        endcase
      end
      `ISOE_RGN_START: nxt_rdata = {24'h0, start_ff[rd_idx], 2'h0};
      `ISOE_RGN_CNT: nxt_rdata = 32'(rd_idx[3] ? cpu_cnt[rd_idx] : frm_cnt[rd_idx]);
      `ISOE_RGN_DATA: nxt_rdata = {24'h0, pop_byte};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Bus handshakes
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      aw_rdy_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `ISOE_RESP_OKAY;
    end else begin
      aw_rdy_ff <= ~aw_rdy_ff & ~bvalid_ff & s_axi_awvalid_i & s_axi_wvalid_i;
      if (wr_en) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? `ISOE_RESP_OKAY : `ISOE_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ar_rdy_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= `ISOE_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ar_rdy_ff <= ~ar_rdy_ff & ~rvalid_ff & s_axi_arvalid_i;
      if (rd_en) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= rd_ok ? `ISOE_RESP_OKAY : `ISOE_RESP_SLVERR;
        rdata_ff <= rd_ok ? nxt_rdata : 32'h0000_0000;
      end else if (s_axi_rready_i) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Software-written control
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_ff <= `ISOE_CTRL_RST;
      valid_ff <= `ISOE_VALID_RST;
      for (int k = 0; k < NEP; k++) begin
        start_ff[k] <= `ISOE_START_RST;
      end
    end else begin
      if (wr_misc & (wr_idx == `ISOE_IDX_CTRL) & s_axi_wstrb_i[0]) begin
        ctrl_ff <= s_axi_wdata_i[1:0];
      end
      if (wr_misc & (wr_idx == `ISOE_IDX_VALID) & s_axi_wstrb_i[0]) begin
        valid_ff[7:0] <= s_axi_wdata_i[7:0];
      end
      if (wr_misc & (wr_idx == `ISOE_IDX_VALID) & s_axi_wstrb_i[1]) begin
        valid_ff[15:8] <= s_axi_wdata_i[15:8];
      end
      if (wr_start) begin
        start_ff[wr_idx] <= s_axi_wdata_i[7:2];
      end
    end
  end

  // Frame timing, flag, bank and error capture
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      frame_start_irq_flag_ff <= 1'b0;
      bank_ff <= 1'b0;
      frame_ff <= 11'h000;
      sof_seen_ff <= 1'b0;
      miss_cnt_ff <= '0;
      err_live_ff <= 8'h00;
      iso_crc_error_flags_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else begin
      frame_start_irq_flag_ff <= nxt_flag;
      irq_ff <= nxt_flag & irq_en;
      if (fs) begin
        bank_ff <= ~bank_ff;
        miss_cnt_ff <= '0;
        iso_crc_error_flags_ff <= err_live_ff | err_set;
        err_live_ff <= 8'h00;
      end else begin
        miss_cnt_ff <= sof_seen_ff ? MISS_W'(miss_cnt_ff + 1'b1) : miss_cnt_ff;
        err_live_ff <= err_live_ff | err_set;
      end
      if (usb_sof_i) begin
        frame_ff <= usb_frame_num_i;
        sof_seen_ff <= 1'b1;
      end
    end
  end

  // FIFO storage writes
  always_ff @(posedge core_clk_i) begin
    if (|cpu_step[NEP-1:NEP/2]) begin
      mem_ff[{~bank_ff, push_addr}] <= s_axi_wdata_i[7:0];
    end
    if (|usb_step[NEP/2-1:0]) begin
      mem_ff[{bank_ff, rx_addr}] <= usb_rx_data_i;
    end
  end

  // IN transmit engine
  always_ff @(posedge core_clk_i) begin
    if (reset_i | fs) begin
      state_ff <= isoe_pkg::ISOE_TX_IDLE;
      tx_ep_ff <= 3'h0;
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      tx_last_ff <= 1'b0;
      zlp_ff <= 1'b0;
    end else begin
      zlp_ff <= in_hit & ~in_has & zlr_en;
      case (state_ff)
        isoe_pkg::ISOE_TX_IDLE: begin
          if (in_hit & in_has) begin
            state_ff <= isoe_pkg::ISOE_TX_SEND;
            tx_ep_ff <= usb_tok_ep_i;
          end
        end
        isoe_pkg::ISOE_TX_SEND: begin
          if (tx_adv) begin
            tx_valid_ff <= tx_more;
            tx_data_ff <= tx_byte;
            tx_last_ff <= tx_is_last;
            if (~tx_more) begin
              state_ff <= isoe_pkg::ISOE_TX_IDLE;
            end
          end
        end
        default: state_ff <= isoe_pkg::ISOE_TX_IDLE;
      endcase
    end
  end

  assign s_axi_awready_o = aw_rdy_ff;
  assign s_axi_wready_o = aw_rdy_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = ar_rdy_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign usb_tx_valid_o = tx_valid_ff;
  assign usb_tx_data_o = tx_data_ff;
  assign usb_tx_last_o = tx_last_ff;
  assign usb_tx_zlp_o = zlp_ff;
  assign cpu_usb_irq_line_o = irq_ff;

  frame_num_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    usb_sof_i |=> frame_ff == $past(usb_frame_num_i))
    else $error("frame number not captured");
  miss_bound_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    miss_cnt_ff < MISS_W'(MISS_CYC))
    else $error("missed frame start not replaced");
  irq_line_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (fs && irq_en && !$past(reset_i)) |=> cpu_usb_irq_line_o)
    else $error("frame start did not reach interrupt line");
  bank_swap_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    fs |=> bank_ff != $past(bank_ff))
    else $error("banks not swapped at frame start");
  flag_clear_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (flag_clr && !fs) |=> !frame_start_irq_flag_ff)
    else $error("flag not cleared by write of one");
  flag_set_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    fs |=> frame_start_irq_flag_ff)
    else $error("frame start lost against clear");
  zlp_reply_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (in_hit && !in_has && zlr_en && !fs) |=> usb_tx_zlp_o && !usb_tx_valid_o)
    else $error("zero-length reply missing");
  no_reply_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (in_hit && !in_has && !zlr_en) |=> !usb_tx_zlp_o && !usb_tx_valid_o)
    else $error("empty endpoint answered");
  invalid_ep_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (usb_in_tok_i && !valid_ff[tok_slot] && state_ff == isoe_pkg::ISOE_TX_IDLE)
    |=> !usb_tx_zlp_o && state_ff == isoe_pkg::ISOE_TX_IDLE)
    else $error("disabled endpoint answered");
  exact_count_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (usb_tx_valid_o && usb_tx_last_o && !fs) |-> usb_cnt[tx_slot] == frm_cnt[tx_slot])
    else $error("sent byte count differs from loaded count");

endmodule : isoe_engine

// *** bench/isoe_host_model.sv ***
`timescale 1ns/1ns
module isoe_host_model (
  input wire logic core_clk_i,
  output logic sof_o,
  output logic [10:0] frame_num_o,
  output logic in_tok_o,
  output logic [2:0] tok_ep_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic [2:0] rx_ep_o,
  output logic rx_end_o,
  output logic rx_crc_bad_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  input wire logic tx_zlp_i
);
  logic [7:0] got_q[$];
  int n_last = 0;
  int n_zlp = 0;
  initial begin
    {sof_o, in_tok_o, rx_valid_o, rx_end_o, rx_crc_bad_o, tx_ready_o} = 6'h00;
    {frame_num_o, tok_ep_o, rx_data_o, rx_ep_o} = 25'h0;
  end
  // Ready toggles so the link is both prompt and slow
  always @(posedge core_clk_i) begin
    tx_ready_o <= ~tx_ready_o;
    if (tx_valid_i && tx_ready_o) begin
      got_q.push_back(tx_data_i);
      n_last += int'(tx_last_i);
    end
    n_zlp += int'(tx_zlp_i);
  end
  // Frame start with its 11-bit number
  task automatic sof(input logic [10:0] num);
    @(posedge core_clk_i);
    sof_o <= 1'b1;
    frame_num_o <= num;
    @(posedge core_clk_i);
    sof_o <= 1'b0;
    frame_num_o <= ~num;
  endtask : sof
  task automatic token(input logic [2:0] ep);
    @(posedge core_clk_i);
    in_tok_o <= 1'b1;
    tok_ep_o <= ep;
    @(posedge core_clk_i);
    in_tok_o <= 1'b0;
    tok_ep_o <= ~ep;
  endtask : token
  // Two-byte OUT packet, low byte first
  task automatic out_pkt(input logic [2:0] ep, input logic [15:0] d, input logic bad);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_i);
      rx_valid_o <= 1'b1;
      rx_ep_o <= ep;
      rx_data_o <= d[8*i+:8];
    end
    @(posedge core_clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~d[15:8];
    rx_end_o <= 1'b1;
    rx_crc_bad_o <= bad;
    @(posedge core_clk_i);
    rx_end_o <= 1'b0;
    rx_crc_bad_o <= ~bad;
    rx_ep_o <= ~ep;
  endtask : out_pkt
endmodule : isoe_host_model

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic clk, rst, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv, irq;
  logic sof, tok, rxv, rxe, crc, txv, txl, txr, zlp;
  logic [7:0] awa, ara, rxd, txd;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic [1:0] br, rr;
  logic [10:0] fnum;
  logic [2:0] tep, rxep;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  isoe_engine #(.MISS_CYC(200)) isoe_engine_inst (.core_clk_i(clk), .reset_i(rst), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .usb_sof_i(sof), .usb_frame_num_i(fnum), .usb_in_tok_i(tok),
    .usb_tok_ep_i(tep), .usb_rx_valid_i(rxv), .usb_rx_data_i(rxd), .usb_rx_ep_i(rxep), .usb_rx_end_i(rxe),
    .usb_rx_crc_bad_i(crc), .usb_tx_valid_o(txv), .usb_tx_data_o(txd), .usb_tx_last_o(txl),
    .usb_tx_ready_i(txr), .usb_tx_zlp_o(zlp), .cpu_usb_irq_line_o(irq));
  isoe_host_model isoe_host_model_inst (.core_clk_i(clk), .sof_o(sof), .frame_num_o(fnum), .in_tok_o(tok),
    .tok_ep_o(tep), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_ep_o(rxep), .rx_end_o(rxe), .rx_crc_bad_o(crc),
    .tx_valid_i(txv), .tx_data_i(txd), .tx_last_i(txl), .tx_ready_o(txr), .tx_zlp_i(zlp));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awa <= a;
    wd <= d;
    {awv, wv, bre} <= 3'h7;
    do @(negedge clk); while (awr !== 1'b1);
    chk({31'h0, wr}, 32'h1, "wready with awready");
    @(posedge clk);
    {awv, wv} <= 2'h0;
    do @(negedge clk); while (bv !== 1'b1);
    chk({30'h0, br}, {30'h0, er}, "write response");
    @(posedge clk);
    bre <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string msg);
    @(posedge clk);
    ara <= a;
    {arv, rre} <= 2'h3;
    do @(negedge clk); while (arr !== 1'b1);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (rv !== 1'b1);
    if (er == 2'h0) chk(rd, exp, msg);
    chk({30'h0, rr}, {30'h0, er}, msg);
    @(posedge clk);
    rre <= 1'b0;
  endtask : rd_chk
  task automatic t_reset();
    rd_chk(8'h00, 32'h0, 2'h0, "ctrl reset");
    rd_chk(8'h0c, 32'h0, 2'h0, "valid reset");
    rd_chk(8'h04, 32'h0, 2'h0, "stat reset");
    rd_chk(8'h14, 32'h0, 2'h2, "unmapped read");
    wr_reg(8'h84, 32'h5, 2'h2);
    ws <= 4'h2;
    wr_reg(8'h0c, 32'hffff, 2'h0);
    wr_reg(8'h00, 32'h3, 2'h0);
    rd_chk(8'h0c, 32'hff00, 2'h0, "valid lane one");
    rd_chk(8'h00, 32'h0, 2'h0, "ctrl lane masked");
    ws <= 4'hf;
  endtask : t_reset
  task automatic t_config();
    wr_reg(8'h0c, 32'h0b01, 2'h0);
    for (int n = 1; n < 16; n++) begin
      wr_reg(8'h40 + 8'(4 * n), (n <= 8) ? 32'h4 : (n == 9) ? 32'h8 : 32'hf, 2'h0);
    end
    rd_chk(8'h68, 32'hc, 2'h0, "start low bits");
    rd_chk(8'h0c, 32'h0b01, 2'h0, "valid readback");
    wr_reg(8'h00, 32'h2, 2'h0);
  endtask : t_config
  task automatic t_frame();
    isoe_host_model_inst.sof(11'h7ff);
    @(negedge clk);
    chk(irq, 32'h1, "irq on frame start");
    rd_chk(8'h08, 32'h7ff, 2'h0, "frame number");
    rd_chk(8'h04, 32'h3, 2'h0, "flag and bank");
    wr_reg(8'h04, 32'h1, 2'h0);
    rd_chk(8'h04, 32'h2, 2'h0, "flag cleared");
    chk(irq, 32'h0, "irq cleared");
  endtask : t_frame
  task automatic t_in();
    wr_reg(8'he0, 32'ha1, 2'h0);
    wr_reg(8'he0, 32'hb2, 2'h0);
    wr_reg(8'he0, 32'hc3, 2'h0);
    rd_chk(8'ha0, 32'h3, 2'h0, "live count");
    isoe_host_model_inst.sof(11'h000);
    rd_chk(8'ha0, 32'h0, 2'h0, "count cleared");
    rd_chk(8'h04, 32'h1, 2'h0, "bank toggled");
    isoe_host_model_inst.token(3'h0);
    repeat (20) @(posedge clk);
    chk(isoe_host_model_inst.got_q.size(), 32'h3, "sent count");
    chk({isoe_host_model_inst.got_q[0], isoe_host_model_inst.got_q[1], isoe_host_model_inst.got_q[2]},
      32'ha1b2c3, "sent bytes");
    chk(isoe_host_model_inst.n_last, 32'h1, "last marker");
    isoe_host_model_inst.token(3'h0);
    repeat (5) @(posedge clk);
    isoe_host_model_inst.token(3'h1);
    repeat (20) @(posedge clk);
    chk(isoe_host_model_inst.got_q.size(), 32'h3, "no resend");
    chk(isoe_host_model_inst.n_zlp, 32'h0, "empty ignored");
    wr_reg(8'h00, 32'h3, 2'h0);
    isoe_host_model_inst.token(3'h2);
    repeat (5) @(posedge clk);
    chk(isoe_host_model_inst.n_zlp, 32'h0, "invalid endpoint");
    isoe_host_model_inst.token(3'h1);
    repeat (5) @(posedge clk);
    isoe_host_model_inst.token(3'h3);
    repeat (5) @(posedge clk);
    chk(isoe_host_model_inst.n_zlp, 32'h2, "zero-length replies");
  endtask : t_in
  task automatic t_out();
    isoe_host_model_inst.out_pkt(3'h0, 16'h5a3c, 1'b1);
    isoe_host_model_inst.out_pkt(3'h1, 16'h1111, 1'b1);
    isoe_host_model_inst.sof(11'h001);
    rd_chk(8'h80, 32'h2, 2'h0, "out count");
    rd_chk(8'h84, 32'h0, 2'h0, "invalid out count");
    rd_chk(8'h10, 32'h1, 2'h0, "crc flag");
    rd_chk(8'hc0, 32'h3c, 2'h0, "pop first");
    rd_chk(8'hc0, 32'h5a, 2'h0, "pop second");
  endtask : t_out
  task automatic t_miss();
    wr_reg(8'h04, 32'h1, 2'h0);
    repeat (240) @(posedge clk);
    rd_chk(8'h04, 32'h1, 2'h0, "synthetic start");
    rd_chk(8'h08, 32'h1, 2'h0, "frame kept");
    chk(irq, 32'h1, "irq after miss");
  endtask : t_miss
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  initial begin
    {rst, awv, wv, bre, arv, rre} = 6'h20;
    {awa, ara, wd, ws} = 52'h000000000000f;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_config();
    t_frame();
    t_in();
    t_out();
    t_miss();
    test_done();
  end
endmodule : tb
